// ===== design/tc_instrument_end.sv
// tc_instrument_end.sv: decodes connection test and science enable commands
// Contract
// - sequence top three bits zero, ground
// - low eleven sequence bits count up from zero
// - separate counter per process and category; code keeps one per command kind, both on the same process and category
// - packet length equals data bytes plus five
// - category field is twelve, private science
// - secondary header version is zero
// - acknowledgement field is 0001
// - connection test type is seventeen
// - connection test subtype is one
// - science enable type is twenty
// - science enable subtype is one
// - science data: nine zero bits, id 71
// - select science report by carried process id
// - answer connection test within four seconds; code answers only once ready and drops tests sent during start-up
// - mirror at stop, then at space view
// - sync or sixty seconds, then engineering telemetry
// - enable passes science packets to link
// - science generated in all but engineering mode
// - stored time applied at next sync pulse
// assumes: link bytes come from logic on the same clock; status pins are asynchronous
`include "tc_map.svh"
module tc_instrument_end
  import tc_pkg::*;
#(
  // sixty seconds of cycles does not fit in 32 bits at this clock
  parameter int unsigned     CLK_HZ      = 200_000_000,
  parameter longint unsigned SYNC_WAIT   = longint'(`SYNC_WAIT_S) * CLK_HZ,
  parameter longint unsigned REPLY_LIMIT = longint'(`REPLY_LIMIT_S) * CLK_HZ
)(
  input  wire logic       CLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic       MIRROR_AT_STOP_IN,
  input  wire logic       MIRROR_AT_SPACE_IN,
  input  wire logic       TIME_SYNC_IN,
  input  wire logic       BROADCAST_SYNC_PULSE_IN,
  input  wire logic       ENG_TLM_ON_IN,
  input  wire logic       ENG_MODE_IN,
  input  wire logic       SCI_PKT_VALID_IN,
  output logic            SCI_GEN_OUT,
  output logic            SCI_PKT_PASS_OUT,
  output logic            TIME_APPLIED_OUT,
  output logic            READY_OUT,
  output logic            REJECT_OUT,
  tc_link_if.instrument   link
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] meta;
  logic [5:0] sync;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      meta <= 6'h00;
      sync <= 6'h00;
    end else begin
      meta <= {SCI_PKT_VALID_IN, ENG_MODE_IN, ENG_TLM_ON_IN, BROADCAST_SYNC_PULSE_IN,
               TIME_SYNC_IN, MIRROR_AT_STOP_IN};
      sync <= meta;
    end
  end
  logic space_meta;
  logic space_sync;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      space_meta <= 1'b0;
      space_sync <= 1'b0;
    end else begin
      space_meta <= MIRROR_AT_SPACE_IN;
      space_sync <= space_meta;
    end
  end
  logic sync_prev;
  logic sync_rise;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) sync_prev <= 1'b0;
    else sync_prev <= sync[2];
  end
  assign sync_rise = sync[2] && !sync_prev;

  // ----------------------------------------
  // start-up sequence
  // ----------------------------------------
  typedef enum logic [2:0] {ST_STOP, ST_SPACE, ST_WAIT, ST_ENG, ST_READY} startup_type;
  startup_type st;
  logic [34:0] wait_cnt;
  logic        time_held;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st <= ST_STOP;
      wait_cnt <= 35'h0;
    end else begin
      unique case (st)
        ST_STOP:  if (sync[0]) st <= ST_SPACE;
        ST_SPACE: if (space_sync) st <= ST_WAIT;
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 35'h1;
          if (time_held || wait_cnt >= 35'(SYNC_WAIT - 1)) st <= ST_ENG;
        end
        ST_ENG:   if (sync[3]) st <= ST_READY;
        ST_READY: st <= ST_READY;
      endcase
    end
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) READY_OUT <= 1'b0;
    else READY_OUT <= (st == ST_READY);
  end

  // time sync: hold until next broadcast pulse, then apply
  logic time_pending;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      time_pending <= 1'b0;
      time_held <= 1'b0;
      TIME_APPLIED_OUT <= 1'b0;
    end else begin
      TIME_APPLIED_OUT <= time_pending && sync_rise;
      if (sync[1]) time_pending <= 1'b1;
      else if (sync_rise) time_pending <= 1'b0;
      if (time_pending && sync_rise) time_held <= 1'b1;
    end
  end

  // ----------------------------------------
  // packet receiver and decode
  // ----------------------------------------
  byte_type    pkt [0:15];
  logic [4:0]  cnt;
  logic [15:0] acc;
  logic [15:0] rx_ck;
  logic        ok_hdr;
  logic        is_test;
  logic        is_sci;
  localparam logic [6:0] pid_bits = `HDR_PID;
  // check word high byte is the one just before the last byte
  assign rx_ck = {pkt[cnt[3:0] - 4'h1], link.tc_data};
  always_comb begin
    ok_hdr = pkt[0] == {`HDR_VER, 1'b1, 1'b1, pid_bits[6:4]}
          && pkt[1] == {pid_bits[3:0], `HDR_CATEGORY}
          && pkt[2][7:6] == `HDR_SEQ_FLAGS && pkt[2][5:3] == `SEQ_SRC_GROUND
          && pkt[6] == {`SEC_VER, `SEC_CKSUM_FLAG, `SEC_ACK}
          && pkt[8] == `SUBTYPE_ONE && pkt[9] == 8'h00;
    is_test = ok_hdr && pkt[7] == `TYPE_TEST && cnt == `BYTES_CONN_TEST - 5'h01
           && {pkt[4], pkt[5]} == `LEN_OFFSET;
    is_sci = ok_hdr && pkt[7] == `TYPE_SCIENCE && cnt == `BYTES_SCI_ENABLE - 5'h01
          && {pkt[4], pkt[5]} == `LEN_OFFSET + 16'h0002
          && pkt[10] == 8'h00 && pkt[11] == {1'b0, `APP_PID_SCIENCE};
  end
  cmd_type cmd;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cnt <= 5'h00;
      acc <= `CKSUM_SEED;
      cmd <= CMD_NONE;
      REJECT_OUT <= 1'b0;
    end else begin
      cmd <= CMD_NONE;
      REJECT_OUT <= 1'b0;
      if (link.tc_valid) begin
        if (cnt < 5'h10) pkt[cnt[3:0]] <= link.tc_data;
        if (link.tc_last) begin
          cnt <= 5'h00;
          acc <= `CKSUM_SEED;
          if (rx_ck == acc && (is_test || is_sci))
            cmd <= is_test ? CMD_CONN_TEST : CMD_SCI_ENABLE;
          else REJECT_OUT <= 1'b1;
        end else begin
          if (cnt != 5'h1f) cnt <= cnt + 5'h01;
          if (cnt > 5'h00) acc <= cksum_step(acc, pkt[cnt[3:0] - 4'h1]);
        end
      end
    end
  end

  // ----------------------------------------
  // actions: reply and science output gate
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) link.conn_report <= 1'b0;
    else link.conn_report <= (cmd == CMD_CONN_TEST) && (st == ST_READY);
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) link.sci_out_en <= 1'b0;
    else if (cmd == CMD_SCI_ENABLE) link.sci_out_en <= 1'b1;
  end
  // generation keeps running whether or not output is enabled
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      SCI_GEN_OUT <= 1'b0;
      SCI_PKT_PASS_OUT <= 1'b0;
    end else begin
      SCI_GEN_OUT <= !sync[4];
      SCI_PKT_PASS_OUT <= sync[5] && !sync[4] && link.sci_out_en;
    end
  end
endmodule

// ===== design/tc_spacecraft_end.sv
// tc_spacecraft_end.sv: builds and sends the two telecommands
// assumes: one byte per cycle on the link, user pulses a send request
`include "tc_map.svh"
module tc_spacecraft_end
  import tc_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic       SEND_TEST_IN,
  input  wire logic       SEND_SCI_IN,
  output logic            BUSY_OUT,
  output logic            REPORT_SEEN_OUT,
  tc_link_if.spacecraft   link
);
  // ----------------------------------------
  // sequence counters, one per command kind
  // ----------------------------------------
  logic [10:0] seq_test;
  logic [10:0] seq_sci;
  logic [4:0]  idx;
  logic [4:0]  total;
  logic        is_sci;
  logic [15:0] acc;
  logic [7:0]  next_byte;
  logic [13:0] seq_field;
  logic [15:0] plen;
  // process id is split over the first two bytes, so keep it as a sliceable constant
  localparam logic [6:0] pid_bits = `HDR_PID;

  assign seq_field = {`SEQ_SRC_GROUND, is_sci ? seq_sci : seq_test};
  assign plen = is_sci ? 16'h0007 : 16'h0005;

  // byte selector for the packet being sent
  always_comb begin
    unique case (idx)
      5'h00: next_byte = {`HDR_VER, 1'b1, 1'b1, pid_bits[6:4]};
      5'h01: next_byte = {pid_bits[3:0], `HDR_CATEGORY};
      5'h02: next_byte = {`HDR_SEQ_FLAGS, seq_field[13:8]};
      5'h03: next_byte = seq_field[7:0];
      5'h04: next_byte = plen[15:8];
      5'h05: next_byte = plen[7:0];
      5'h06: next_byte = {`SEC_VER, `SEC_CKSUM_FLAG, `SEC_ACK};
      5'h07: next_byte = is_sci ? `TYPE_SCIENCE : `TYPE_TEST;
      5'h08: next_byte = `SUBTYPE_ONE;
      5'h09: next_byte = 8'h00;
      5'h0a: next_byte = is_sci ? 8'h00 : acc[15:8];
      5'h0b: next_byte = is_sci ? {1'b0, `APP_PID_SCIENCE} : acc[7:0];
      5'h0c: next_byte = acc[15:8];
      default: next_byte = acc[7:0];
    endcase
  end

  // ----------------------------------------
  // send sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BUSY_OUT <= 1'b0;
      idx <= 5'h00;
      is_sci <= 1'b0;
      acc <= `CKSUM_SEED;
      link.tc_valid <= 1'b0;
      link.tc_last <= 1'b0;
      link.tc_data <= 8'h00;
      seq_test <= 11'h000;
      seq_sci <= 11'h000;
    end else if (!BUSY_OUT) begin
      link.tc_valid <= 1'b0;
      link.tc_last <= 1'b0;
      if (SEND_TEST_IN || SEND_SCI_IN) begin
        BUSY_OUT <= 1'b1;
        is_sci <= !SEND_TEST_IN; // test wins when both asked
        idx <= 5'h00;
        acc <= `CKSUM_SEED;
      end
    end else begin
      link.tc_valid <= 1'b1;
      link.tc_data <= next_byte;
      if (idx < total - 5'h02) acc <= cksum_step(acc, next_byte);
      link.tc_last <= (idx == total - 5'h01);
      idx <= idx + 5'h01;
      if (idx == total - 5'h01) begin
        BUSY_OUT <= 1'b0;
        if (is_sci) seq_sci <= seq_sci + 11'h001;
        else seq_test <= seq_test + 11'h001;
      end
    end
  end

  assign total = is_sci ? `BYTES_SCI_ENABLE : `BYTES_CONN_TEST;

  // report pulses seen from the instrument
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) REPORT_SEEN_OUT <= 1'b0;
    else REPORT_SEEN_OUT <= link.conn_report;
  end
endmodule

// ===== inc/tc_link_if.sv
// tc_link_if.sv: byte-wide link between spacecraft end and instrument end
// assumes: both ends on the same clock; one byte per valid cycle
interface tc_link_if;
  logic [7:0] tc_data;
  logic       tc_valid;
  logic       tc_last;
  logic       conn_report;
  logic       sci_out_en;
  modport spacecraft (output tc_data, output tc_valid, output tc_last,
                      input conn_report, input sci_out_en);
  modport instrument (input tc_data, input tc_valid, input tc_last,
                      output conn_report, output sci_out_en);
endinterface

// ===== inc/tc_map.svh
// tc_map.svh: telecommand field values, byte counts and timing figures
// assumes: included by the two link ends only, not by the package, 200 MHz clock
`ifndef TC_MAP_SVH
`define TC_MAP_SVH
`define CLK_PERIOD_NS      5
`define HDR_VER            3'h0
`define HDR_PID            7'h47
`define HDR_CATEGORY       4'hc
`define HDR_SEQ_FLAGS      2'h3
`define SEQ_SRC_GROUND     3'h0
`define LEN_OFFSET         16'h0005
`define SEC_VER            3'h0
`define SEC_CKSUM_FLAG     1'h1
`define SEC_ACK            4'h1
`define TYPE_TEST          8'h11
`define TYPE_SCIENCE       8'h14
`define SUBTYPE_ONE        8'h01
`define APP_PID_SCIENCE    7'h47
`define BYTES_CONN_TEST    5'h0c
`define BYTES_SCI_ENABLE   5'h0e
`define REPLY_LIMIT_S      4
`define SYNC_WAIT_S        60
`define CKSUM_SEED         16'hffff
`endif

// ===== inc/tc_pkg.sv
// tc_pkg.sv: shared types for the telecommand link
// assumes: tc_map.svh supplies the constants
package tc_pkg;
  typedef enum logic [1:0] {CMD_NONE, CMD_CONN_TEST, CMD_SCI_ENABLE} cmd_type;
  typedef logic [7:0] byte_type;
  // running check word: xor then rotate left by one of each byte
  function automatic logic [15:0] cksum_step(input logic [15:0] acc, input logic [7:0] b);
    logic [15:0] s;
    s = acc ^ {8'h00, b};
    cksum_step = {s[14:0], s[15]};
  endfunction
endpackage

// ===== sim/tc_link_assertions.sv
// tc_link_assertions.sv: checker on the link between the two ends
// assumes: instantiated beside the interface, one clock, async low reset
module tc_link_assertions (
  input wire logic       CLK_IN,
  input wire logic       RSTN_IN,
  input wire logic [7:0] tc_data,
  input wire logic       tc_valid,
  input wire logic       tc_last,
  input wire logic       conn_report,
  input wire logic       sci_out_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx;
  logic [7:0] len;
  logic [7:0] typ;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // ----------------
  // byte position
  // ----------------
  // type and length kept so the trailer checks know the packet kind
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      idx <= 4'h0;
      len <= 8'h00;
      typ <= 8'h00;
    end else if (tc_valid) begin
      idx <= tc_last ? 4'h0 : idx + 4'h1;
      if (idx == 4'h5) len <= tc_data;
      if (idx == 4'h7) typ <= tc_data;
    end
  end
  sequence last_byte_s;
    tc_valid && tc_last;
  endsequence
  sequence decoded_s;
    $past(tc_last, 2) && $past(tc_valid, 2);
  endsequence
  first_byte_a: assert property (tc_valid && idx == 4'h0 |-> tc_data == 8'h1c)
    else $error("first header byte wrong");
  category_a: assert property (tc_valid && idx == 4'h1 |-> tc_data == 8'h7c)
    else $error("category byte wrong");
  seq_source_a: assert property (tc_valid && idx == 4'h2 |-> tc_data[7:3] == 5'h18)
    else $error("sequence source bits wrong");
  sec_header_a: assert property (tc_valid && idx == 4'h6 |-> tc_data == 8'h11)
    else $error("secondary header byte wrong");
  service_type_a: assert property (tc_valid && idx == 4'h7 |->
    tc_data == 8'h11 || tc_data == 8'h14)
    else $error("service type wrong");
  subtype_a: assert property (tc_valid && idx == 4'h8 |-> tc_data == 8'h01)
    else $error("subtype wrong");
  app_pid_a: assert property (tc_valid && idx == 4'hb && typ == 8'h14 |->
    tc_data == 8'h47)
    else $error("science process id wrong");
  pkt_length_a: assert property (last_byte_s |-> {4'h0, idx} == len + 8'h06 &&
    len == (typ == 8'h14 ? 8'h07 : 8'h05))
    else $error("packet length wrong");
  report_cause_a: assert property (conn_report |->
    decoded_s ##0 typ == 8'h11 ##1 !conn_report)
    else $error("report without test command");
  enable_cause_a: assert property ($rose(sci_out_en) |-> decoded_s ##0 typ == 8'h14)
    else $error("enable without science command");
  enable_hold_a: assert property (sci_out_en |=> sci_out_en)
    else $error("science enable dropped");
endmodule

// ===== sim/telecommand_test_and_science_enable_tb_top.sv
// tb top: both link ends face each other; a second instrument sees a faulty link
// assumes: wait for time sync shortened to 100 cycles, 200 MHz clock
module telecommand_test_and_science_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tc_pkg::*;
  logic clk = 0, rstn = 0, s_test = 0, s_sci = 0, stop = 0, space = 0, tsync = 0;
  logic bsync = 0, eng_tlm = 0, eng = 0, sci_v = 0;
  logic busy, seen, gen, pass, tapp, rej2, rej, rdy;
  byte_type pkt [14];
  byte_type bad [12] = '{8'h1c, 8'h7c, 8'hc0, 8'h00, 8'h00, 8'h05,
                        8'h11, 8'h11, 8'h01, 8'h00, 8'h00, 8'h00};
  int n_mismatch = 0, num_checks = 0, n_rep = 0, n_tap = 0, n_rej = 0, n_bad = 0;
  int cyc = 0, mi = 0, n_rej_good = 0;
  tc_link_if link ();
  tc_link_if bad_link ();
  always #2.5 clk = ~clk;
  tc_spacecraft_end tc_spacecraft_end_i (.CLK_IN(clk), .RSTN_IN(rstn), .SEND_TEST_IN(s_test),
    .SEND_SCI_IN(s_sci), .BUSY_OUT(busy), .REPORT_SEEN_OUT(seen), .link(link));
  tc_instrument_end #(.SYNC_WAIT(100)) tc_instrument_end_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .MIRROR_AT_STOP_IN(stop), .MIRROR_AT_SPACE_IN(space), .TIME_SYNC_IN(tsync),
    .BROADCAST_SYNC_PULSE_IN(bsync), .ENG_TLM_ON_IN(eng_tlm), .ENG_MODE_IN(eng),
    .SCI_PKT_VALID_IN(sci_v), .SCI_GEN_OUT(gen), .SCI_PKT_PASS_OUT(pass),
    .TIME_APPLIED_OUT(tapp), .READY_OUT(rdy), .REJECT_OUT(rej), .link(link));
  // faulty sender stands in for the spacecraft end here
  tc_instrument_end #(.SYNC_WAIT(100)) tc_instrument_end_bad_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .MIRROR_AT_STOP_IN(stop), .MIRROR_AT_SPACE_IN(space), .TIME_SYNC_IN(tsync),
    .BROADCAST_SYNC_PULSE_IN(bsync), .ENG_TLM_ON_IN(eng_tlm), .ENG_MODE_IN(eng),
    .SCI_PKT_VALID_IN(sci_v), .SCI_GEN_OUT(), .SCI_PKT_PASS_OUT(), .TIME_APPLIED_OUT(),
    .READY_OUT(), .REJECT_OUT(rej2), .link(bad_link));
  tc_link_assertions tc_link_assertions_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .tc_data(link.tc_data), .tc_valid(link.tc_valid), .tc_last(link.tc_last),
    .conn_report(link.conn_report), .sci_out_en(link.sci_out_en));
  // ----------------
  // monitor and timeout
  // ----------------
  // pulses are counted so a one-cycle output is never missed
  always @(posedge clk) begin
    cyc++;
    if (link.tc_valid === 1'b1) begin
      pkt[mi] = link.tc_data;
      mi = (link.tc_last === 1'b1) ? 0 : mi + 1;
    end
    if (seen === 1'b1) n_rep++;
    if (tapp === 1'b1) n_tap++;
    if (rej2 === 1'b1) n_rej++;
    if (rej === 1'b1) n_rej_good++;
    if (bad_link.conn_report === 1'b1) n_bad++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // request pulse, then the fixed walk of a packet plus the reply slot
  task automatic send(input bit sci);
    @(posedge clk);
    if (sci) s_sci <= 1'b1;
    else s_test <= 1'b1;
    @(posedge clk);
    s_sci <= 1'b0;
    s_test <= 1'b0;
    repeat (18) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    bad_link.tc_data = 8'h00;
    bad_link.tc_valid = 1'b0;
    bad_link.tc_last = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    space <= 1'b1;
    eng_tlm <= 1'b1;
    repeat (40) @(posedge clk);
    check(ready_low(), "ready before wait");
    send(0);
    check(n_rep == 0, "report before start-up");
    check(pkt[3] === 8'h00 && pkt[5] === 8'h05 && busy === 1'b0, "first test header");
    repeat (100) @(posedge clk);
    check(rdy === 1'b1, "not ready");
    $display("startup test done");
    send(0);
    check(n_rep == 1, "no connection report");
    check(pkt[3] === 8'h01, "test count");
    sci_v <= 1'b1;
    repeat (6) @(posedge clk);
    check(pass === 1'b0 && gen === 1'b1, "passed before enable");
    send(1);
    check(pass === 1'b1, "science not passed");
    check(pkt[3] === 8'h00 && pkt[5] === 8'h07 && pkt[11] === 8'h47, "science header");
    eng <= 1'b1;
    repeat (6) @(posedge clk);
    check(gen === 1'b0 && pass === 1'b0, "engineering mode");
    $display("command test done");
    tsync <= 1'b1;
    repeat (6) @(posedge clk);
    bsync <= 1'b1;
    repeat (6) @(posedge clk);
    check(n_tap == 1, "time not applied");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      bad_link.tc_valid <= 1'b1;
      bad_link.tc_data <= bad[i];
      bad_link.tc_last <= (i == 11);
    end
    @(posedge clk);
    bad_link.tc_valid <= 1'b0;
    bad_link.tc_last <= 1'b0;
    repeat (6) @(posedge clk);
    check(n_rej == 1 && n_bad == 0 && n_rej_good == 0, "bad checksum accepted");
    $display("fault test done");
    end_sim();
  end
  function automatic bit ready_low();
    return rdy === 1'b0;
  endfunction
endmodule
